/* ext_mem_bus_pkg.sv */
// shared constants and types for the external memory strobe controller
package ext_mem_bus_pkg;
    localparam int WAIT_CNT_W = 4;
    localparam logic [3:0] WAIT_CNT_RST = 4'h0;
    localparam logic STROBE_IDLE = 1'b1;

    // bus cycle request from the cpu core
    typedef struct packed {
        logic start;
        logic write;
        logic external;
        logic wide;
        logic low_byte;
        logic high_byte;
    } bus_req_t;

    // active-low strobes towards the pins
    typedef struct packed {
        logic read_n;
        logic write_n;
        logic lower_byte_write_n;
        logic upper_byte_write_n;
    } strobe_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ACCESS = 2'b01,
        S_WAIT = 2'b11,
        S_DONE = 2'b10
    } bus_state_t;
endpackage

/* ext_mem_bus_strobes.sv */
// external bus wait-state and write strobe controller
`timescale 1ns/1ns
`default_nettype none
module ext_mem_bus_strobes
    import ext_mem_bus_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire bus_req_t req,
    input wire logic [WAIT_CNT_W-1:0] max_waits,
    input wire logic ready,
    output strobe_t strobe,
    output logic busy,
    output logic cycle_done
);

    // ------------------------------------------------------------
    // ready synchroniser
    // ------------------------------------------------------------
    logic ready_meta;
    logic ready_sync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_meta <= 1'b1;
            ready_sync <= 1'b1;
        end else begin
            ready_meta <= ready;
            ready_sync <= ready_meta;
        end
    end

    // ------------------------------------------------------------
    // cycle sequencing
    // ------------------------------------------------------------
    bus_state_t state;
    bus_req_t cur;
    logic [WAIT_CNT_W-1:0] wait_cnt;
    logic hold;

    // stretch only external cycles with ready low and budget left
    assign hold = cur.external && !ready_sync && (wait_cnt < max_waits);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (req.start) begin
                        state <= S_ACCESS;
                    end
                end
                S_ACCESS, S_WAIT: begin
                    if (hold) begin
                        state <= S_WAIT;
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else if (state == S_IDLE && req.start) begin
            cur <= req;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= WAIT_CNT_RST;
        end else if (state == S_IDLE) begin
            wait_cnt <= WAIT_CNT_RST;
        end else if ((state == S_ACCESS || state == S_WAIT) && hold) begin
            wait_cnt <= wait_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    strobe_t next_strobe;
    logic active;
    logic ext_wr;

    assign active = (state == S_IDLE && req.start) || (state != S_IDLE && state != S_DONE && hold)
        || (state == S_ACCESS && hold);

    always_comb begin
        next_strobe = '1;
        if (state == S_IDLE && req.start && req.external) begin
            next_strobe.read_n = req.write;
            next_strobe.write_n = !req.write;
            next_strobe.lower_byte_write_n =
                !(req.write && (!req.wide || req.low_byte));
            next_strobe.upper_byte_write_n =
                !(req.write && (!req.wide || req.high_byte));
        end else if ((state == S_ACCESS || state == S_WAIT) && hold) begin
            next_strobe = strobe;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strobe <= '1;
            busy <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            strobe <= next_strobe;
            busy <= active || (state == S_ACCESS) || (state == S_WAIT);
            cycle_done <= (state == S_ACCESS || state == S_WAIT) && !hold;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ready_high_no_wait;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && ready_sync) |=> (state == S_DONE);
    endproperty
    a_ready_high_no_wait: assert property (p_ready_high_no_wait)
        else $error("wait with ready high");

    property p_wait_bound;
        @(posedge clock) disable iff (!rst_n)
        (state == S_WAIT) |-> (wait_cnt <= max_waits);
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("wait count beyond maximum");

    property p_internal_no_wait;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && !cur.external) |=> (state == S_DONE);
    endproperty
    a_internal_no_wait: assert property (p_internal_no_wait)
        else $error("internal access waited");

    property p_write_only_ext;
        @(posedge clock) disable iff (!rst_n)
        !strobe.write_n |-> (cur.external && cur.write && state != S_IDLE);
    endproperty
    a_write_only_ext: assert property (p_write_only_ext)
        else $error("stray write strobe");

    property p_high_strobe;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && cur.external && cur.write && (!cur.wide || cur.high_byte))
            |-> !strobe.upper_byte_write_n;
    endproperty
    a_high_strobe: assert property (p_high_strobe)
        else $error("high strobe missing");

    property p_low_strobe;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && cur.external && cur.write && (!cur.wide || cur.low_byte))
            |-> !strobe.lower_byte_write_n;
    endproperty
    a_low_strobe: assert property (p_low_strobe)
        else $error("low strobe missing");

    property p_read_only_ext;
        @(posedge clock) disable iff (!rst_n)
        !strobe.read_n |-> (cur.external && !cur.write && state != S_IDLE);
    endproperty
    a_read_only_ext: assert property (p_read_only_ext)
        else $error("stray read strobe");

    property p_count_cleared;
        @(posedge clock) disable iff (!rst_n)
        (state == S_IDLE && req.start) |=> (wait_cnt == WAIT_CNT_RST);
    endproperty
    a_count_cleared: assert property (p_count_cleared)
        else $error("wait count not cleared");

    // the end of a cycle is flagged for one clock only
    property p_done_pulse;
        @(posedge clock) disable iff (!rst_n)
        cycle_done |=> !cycle_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("cycle done longer than one clock");

    // ready low with budget left adds exactly one wait state
    property p_wait_step;
        @(posedge clock) disable iff (!rst_n)
        ((state == S_ACCESS || state == S_WAIT) && cur.external && !ready_sync
            && (wait_cnt < max_waits))
            |=> (state == S_WAIT) && (wait_cnt == $past(wait_cnt) + 1'b1);
    endproperty
    a_wait_step: assert property (p_wait_step)
        else $error("wait state not added");

    // an exhausted budget ends the cycle whatever ready does
    property p_budget_end;
        @(posedge clock) disable iff (!rst_n)
        ((state == S_ACCESS || state == S_WAIT) && (wait_cnt == max_waits)) |=> (state == S_DONE);
    endproperty
    a_budget_end: assert property (p_budget_end)
        else $error("wait beyond budget");

    property p_wait_strobes_held;
        @(posedge clock) disable iff (!rst_n)
        (state == S_WAIT) |-> $stable(strobe);
    endproperty
    a_wait_strobes_held: assert property (p_wait_strobes_held)
        else $error("strobes moved during wait");

    property p_release_with_done;
        @(posedge clock) disable iff (!rst_n)
        cycle_done |-> (strobe == '1) && (state == S_DONE);
    endproperty
    a_release_with_done: assert property (p_release_with_done)
        else $error("strobes not released at cycle end");

    property p_internal_no_strobe;
        @(posedge clock) disable iff (!rst_n)
        (state != S_IDLE && !cur.external) |-> (strobe == '1);
    endproperty
    a_internal_no_strobe: assert property (p_internal_no_strobe)
        else $error("strobe on internal access");

    property p_low_strobe_off;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && cur.wide && !cur.low_byte) |-> strobe.lower_byte_write_n;
    endproperty
    a_low_strobe_off: assert property (p_low_strobe_off)
        else $error("low strobe on upper byte write");

    property p_high_strobe_off;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && cur.wide && !cur.high_byte) |-> strobe.upper_byte_write_n;
    endproperty
    a_high_strobe_off: assert property (p_high_strobe_off)
        else $error("high strobe on lower byte write");

    property p_read_strobe;
        @(posedge clock) disable iff (!rst_n)
        (state == S_ACCESS && cur.external && !cur.write) |-> !strobe.read_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe missing");

endmodule
`default_nettype wire

/* mem_ready_model.sv */
// external memory model that stretches bus cycles through the ready pin
`timescale 1ns/1ns
`default_nettype none
module mem_ready_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow,
    output logic ready
);
    // ----------------------------------------
    // ready pin
    // ----------------------------------------
    // slow memory holds ready low for the whole cycle
    always_ff @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b1;
        end else begin
            ready <= !slow;
        end
    end
endmodule
`default_nettype wire

/* tb_ext_mem_bus_strobes.sv */
// self-checking bench of the external bus strobe controller
`timescale 1ns/1ns
`default_nettype none
module tb_ext_mem_bus_strobes
    import ext_mem_bus_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    bus_req_t req = '0;
    logic [WAIT_CNT_W-1:0] max_waits = 4'h0;
    logic slow = 1'b0;
    logic ready;
    strobe_t strobe;
    strobe_t exp_strobe;
    logic busy;
    logic cycle_done;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int k;
    int waits;
    int exp_len;
    int exp_len_q[$];
    // ----------------------------------------
    // clock, timeout and instances
    // ----------------------------------------
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    mem_ready_model mem_ready_model_i (.clock(clock), .rst_n(rst_n), .slow(slow), .ready(ready));
    ext_mem_bus_strobes ext_mem_bus_strobes_i (.clock(clock), .rst_n(rst_n), .req(req),
        .max_waits(max_waits), .ready(ready), .strobe(strobe), .busy(busy),
        .cycle_done(cycle_done));
    // ----------------------------------------
    // compare and verdict
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // random bus cycles against the reference
    // ----------------------------------------
    initial begin
        void'($urandom(1668));
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        check("reset strobes", {4'h0, strobe}, 8'h0F);
        for (int t = 0; t < 80; t++) begin
            @(negedge clock);
            slow = 1'($urandom);
            // let the two-flop ready synchroniser settle
            repeat (4) @(negedge clock);
            req = bus_req_t'($urandom);
            req.start = 1'b1;
            max_waits = WAIT_CNT_W'($urandom % 6);
            waits = (req.external && slow) ? int'(max_waits) : 0;
            exp_len_q.push_back(2 + waits);
            exp_strobe.read_n = !(req.external && !req.write);
            exp_strobe.write_n = !(req.external && req.write);
            exp_strobe.lower_byte_write_n = !(req.external && req.write &&
                (!req.wide || req.low_byte));
            exp_strobe.upper_byte_write_n = !(req.external && req.write &&
                (!req.wide || req.high_byte));
            @(negedge clock);
            req.start = 1'b0;
            k = 1;
            check("strobe", 8'(strobe), 8'(exp_strobe));
            check("read strobe", 8'(strobe.read_n), 8'(exp_strobe.read_n));
            check("busy", {7'h0, busy}, 8'h01);
            while (cycle_done !== 1'b1 && k < 40) begin
                check("held strobe", 8'(strobe), 8'(exp_strobe));
                @(negedge clock);
                k++;
            end
            exp_len = exp_len_q.pop_front();
            check("cycle length", 8'(k), 8'(exp_len));
            check("released strobes", {4'h0, strobe}, 8'h0F);
            @(negedge clock);
            check("done pulse", {7'h0, cycle_done}, 8'h00);
            check("busy after", {7'h0, busy}, 8'h00);
        end
        close_out();
    end
endmodule
`default_nettype wire
